// ---- core/mcap_pkg.sv ----
// constants for the multichannel audio serial transmit port
package mcap_pkg;
	// system clock
	localparam int CLK_HZ = 100_000_000;
	localparam logic [31:0] CLK_KHZ = 32'h0001_86a0;
	// register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_MHALF = 8'h01;
	localparam logic [7:0] A_SLOT0 = 8'h08;
	localparam logic [7:0] A_SAMP0 = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h18;
	localparam logic [7:0] A_FCLKS = 8'h19;
	// control register fields
	localparam int F_FMT = 0;
	localparam int F_WLEN = 2;
	localparam int F_TRI = 4;
	localparam int F_HOLD = 5;
	localparam int F_LANE2 = 6;
	localparam int F_DAISY = 7;
	localparam int F_FULL = 8;
	localparam int F_MASTER = 9;
	localparam int F_INV = 10;
	localparam int F_OFS = 11;
	localparam logic [15:0] CTRL_RST = 16'h000d;
	localparam logic [11:0] MHALF_RST = 12'h020;
	// slot entry: enable above a six-bit slot number
	localparam int F_SLOT_EN = 6;
	localparam int NCH = 8;
	localparam logic [7:0] LANE2_MASK = 8'hf0;
	// framing and word length codes
	localparam logic [1:0] FMT_I2S = 2'b01;
	localparam logic [1:0] FMT_LJ = 2'b10;
	localparam logic [1:0] WL_16 = 2'b00;
	localparam logic [1:0] WL_20 = 2'b01;
	localparam logic [1:0] WL_24 = 2'b10;
	// last bit index of a slot for 16/20/24/32 bits
	localparam logic [4:0] WL_LAST_16 = 5'h0f;
	localparam logic [4:0] WL_LAST_20 = 5'h13;
	localparam logic [4:0] WL_LAST_24 = 5'h17;
	localparam logic [4:0] WL_LAST_32 = 5'h1f;
	// master bit clock generation
	localparam int MASTER_BCLK_HZ = 12_500_000;
	localparam logic [3:0] BCLK_HALF_CLKS =
		4'(CLK_HZ / (2 * MASTER_BCLK_HZ));
	// clock detection limits
	localparam int FR_MAX_HZ = 768_000;
	localparam int FR_MIN_HZ = 7_350;
	localparam logic [15:0] FR_MIN_CLKS = 16'(CLK_HZ / FR_MAX_HZ);
	localparam int FR_MAX_CLKS_DEF = (CLK_HZ + FR_MIN_HZ - 1) / FR_MIN_HZ;
	localparam logic [31:0] BCLK_MAX_KHZ = 32'h0000_6000;
	localparam logic [31:0] BCLK_MIN_KHZ = 32'h0000_00fa;
endpackage

// ---- core/mcap_top.sv ----
// multichannel i2s / left-justified audio serial transmit port
//
// Function
// RULE1: i2s: left slot 0 msb on second falling bclk after frame sync falls
// RULE2: i2s: right slot 0 msb on second falling bclk after frame sync rises
// RULE3: i2s: frame sync driven and data changed on falling bit clock edges
// RULE4: slots of one half-frame follow back to back, many slots per half
// RULE5: host gives enough bit clocks per frame for all active slots
// RULE6: i2s: host holds frame sync low/high long enough for its slots
// RULE7: lj: left slot 0 msb in same cycle frame sync rises
// RULE8: lj: right slot 0 msb in same cycle frame sync falls
// RULE9: lj: later data bits and driven frame sync change on falling edges
// RULE10: lj: host holds frame sync high/low long enough for its slots
// RULE11: host should program a slot offset for fast lj bit clocks
// RULE12: each channel may sit on any of 64 slot positions
// RULE13: optional high impedance on slots no channel uses
// RULE14: optional bus holder keeps last driven data level
// RULE15: general output pin may carry a second data lane
// RULE16: general input pin feeds upstream data for daisy chaining
// RULE17: optional mode gives receiver a full bit clock per bit
// RULE18: port is master or slave for bit clock and frame sync
// RULE19: four strapped addresses plus a broadcast write
// RULE20: measure frame rate and ratio, set clock dividers unaided; code only reports the measurements
// RULE21: accept 48k family 8k-768k, ratios 16-2048, bclk to 24.576 MHz
// RULE22: accept 44.1k family 7.35k-705.6k, ratios 16-2048
// RULE23: unsupported clocking flags a clock error and mutes data
// RULE24: word length code selects 16, 20, 24 or 32 bits, 32 default
// RULE25: idle slots drive zero when high impedance is off
`timescale 1ns/1ps
`default_nettype none
module mcap_top
	import mcap_pkg::*;
#(
	parameter int FR_MAX_CLKS = FR_MAX_CLKS_DEF
) (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic [1:0]  i_addr_strap,
	input  wire logic [1:0]  i_target,
	input  wire logic        i_broadcast,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_bclk,
	input  wire logic        i_frame_sync_pin,
	input  wire logic        i_general_input_pin,
	output logic             o_bclk,
	output logic             o_bclk_oe,
	output logic             o_frame_sync_pin,
	output logic             o_frame_sync_oe,
	output logic             o_dout,
	output logic             o_dout_oe,
	output logic             o_general_output_pin,
	output logic             o_general_output_oe,
	output logic             o_keeper_en,
	output logic             o_clock_error,
	output logic             o_cfg_valid,
	output logic      [11:0] o_cfg_ratio,
	output logic      [15:0] o_cfg_frame_clks
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	logic [15:0] ctrl;
	logic [11:0] mhalf;
	logic [6:0]  slot_cfg [NCH];
	logic [31:0] samp [NCH];
	logic [1:0]  strap;
	logic        sel_wr;
	logic        sel_rd;

	// strap caught while reset is held; broadcast writes reach every device
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			strap <= i_addr_strap;
		end
	end
	assign sel_wr = i_wr & (i_broadcast | (i_target == strap)); // RULE19
	assign sel_rd = i_rd & ~i_broadcast & (i_target == strap);

	// control and master half-frame length registers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl <= CTRL_RST; // RULE24
			mhalf <= MHALF_RST;
		end else if (sel_wr && i_addr == A_CTRL) begin
			ctrl <= i_wdata[15:0];
		end else if (sel_wr && i_addr == A_MHALF) begin
			mhalf <= i_wdata[11:0];
		end
	end

	logic [1:0] fmt;
	logic [1:0] wlen;
	logic       tri_en, hold_en, lane2_en, daisy_en, full_en;
	logic       master, inv;
	logic [4:0] ofs;
	logic       is_i2s;
	logic [4:0] wl_last;
	assign fmt = ctrl[F_FMT +: 2];
	assign wlen = ctrl[F_WLEN +: 2];
	assign tri_en = ctrl[F_TRI];
	assign hold_en = ctrl[F_HOLD];
	assign lane2_en = ctrl[F_LANE2];
	assign daisy_en = ctrl[F_DAISY];
	assign full_en = ctrl[F_FULL];
	assign master = ctrl[F_MASTER];
	assign inv = ctrl[F_INV];
	assign ofs = ctrl[F_OFS +: 5];
	assign is_i2s = (fmt == FMT_I2S);

	// word length code to last bit index of a slot
	always_comb begin
		case (wlen)
			WL_16: wl_last = WL_LAST_16; // RULE24
			WL_20: wl_last = WL_LAST_20;
			WL_24: wl_last = WL_LAST_24;
			default: wl_last = WL_LAST_32;
		endcase
	end

	// master clock generator: frame sync toggles as bit clock falls
	logic [3:0]  m_div;
	logic [11:0] m_cnt;
	always_ff @(posedge i_clk) begin
		if (i_srst || !master) begin
			m_div <= 4'h0;
			m_cnt <= 12'h000;
			o_bclk <= 1'b1;
			o_frame_sync_pin <= 1'b0;
		end else if (m_div == BCLK_HALF_CLKS - 4'h1) begin // RULE18
			m_div <= 4'h0;
			o_bclk <= ~o_bclk;
			if (o_bclk && m_cnt == mhalf - 12'h001) begin
				m_cnt <= 12'h000;
				o_frame_sync_pin <= ~o_frame_sync_pin; // RULE3 RULE9
			end else if (o_bclk) begin
				m_cnt <= m_cnt + 12'h001;
			end
		end else begin
			m_div <= m_div + 4'h1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_bclk_oe <= 1'b0;
			o_frame_sync_oe <= 1'b0;
		end else begin
			o_bclk_oe <= master;
			o_frame_sync_oe <= master;
		end
	end

	// edge detection on the bit clock in use
	logic bclk_lvl, fs_lvl, bclk_q, fs_q, fall, rise;
	assign bclk_lvl = master ? o_bclk : (i_bclk ^ inv);
	assign fs_lvl = master ? o_frame_sync_pin : i_frame_sync_pin;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			bclk_q <= 1'b1;
			fs_q <= 1'b0;
		end else begin
			bclk_q <= bclk_lvl;
			fs_q <= fs_lvl;
		end
	end
	assign fall = bclk_q & ~bclk_lvl;
	assign rise = ~bclk_q & bclk_lvl;

	// slot sequencer, evaluated at each falling bit clock edge
	logic       fs_seen, hs, e_side, emit, wrap;
	logic [5:0] skip, slot, e_skip, e_slot, delay;
	logic [4:0] sbit, e_bit;
	logic [5:0] gslot;
	assign hs = (fs_lvl != fs_seen);
	assign e_side = is_i2s ? fs_lvl : ~fs_lvl;
	assign delay = {1'b0, ofs} + {5'h00, is_i2s}; // RULE1 RULE2 RULE7 RULE8
	assign e_skip = hs ? delay : skip;
	assign e_bit = hs ? 5'h00 : sbit;
	assign e_slot = hs ? 6'h00 : slot;
	assign emit = (e_skip == 6'h00) && !e_slot[5];
	assign wrap = (e_bit == wl_last);
	assign gslot = {e_side, e_slot[4:0]};
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			fs_seen <= 1'b0;
			skip <= 6'h00;
			sbit <= 5'h00;
			slot <= 6'h20;
		end else if (fall) begin
			fs_seen <= fs_lvl;
			skip <= (e_skip == 6'h00) ? 6'h00 : e_skip - 6'h01;
			if (emit) begin // RULE4
				sbit <= wrap ? 5'h00 : e_bit + 5'h01;
				slot <= wrap ? e_slot + 6'h01 : e_slot;
			end else begin
				sbit <= e_bit;
				slot <= e_slot;
			end
		end
	end

	// per channel registers, slot match and bit select
	logic [NCH-1:0] hit, bitv;
	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					slot_cfg[c] <= 7'h00;
					samp[c] <= 32'h0000_0000;
				end else if (sel_wr && i_addr == A_SLOT0 + 8'(c)) begin
					slot_cfg[c] <= i_wdata[6:0];
				end else if (sel_wr && i_addr == A_SAMP0 + 8'(c)) begin
					samp[c] <= i_wdata;
				end
			end
			assign hit[c] = emit && slot_cfg[c][F_SLOT_EN] &&
				(slot_cfg[c][5:0] == gslot); // RULE12
			assign bitv[c] = samp[c][~e_bit];
		end
	endgenerate

	// lane split and idle-slot policy
	logic [NCH-1:0] m1, m0;
	logic [1:0]     n0, n1;
	function automatic logic [1:0] drv(input logic on, input logic h,
		input logic v, input logic chain);
		if (!on) begin
			drv = 2'b00;
		end else if (h) begin
			drv = {1'b1, v & ~o_clock_error}; // RULE23
		end else if (chain) begin
			drv = {1'b1, i_general_input_pin}; // RULE16
		end else if (tri_en) begin
			drv = 2'b00; // RULE13
		end else begin
			drv = 2'b10; // RULE25
		end
	endfunction
	assign m1 = lane2_en ? LANE2_MASK : 8'h00; // RULE15
	assign m0 = ~m1;
	assign n0 = drv(1'b1, |(hit & m0), |(hit & bitv & m0), daisy_en);
	assign n1 = drv(lane2_en, |(hit & m1), |(hit & bitv & m1), 1'b0);

	// launch on the falling edge, or one half cycle later on the rising edge
	logic [1:0] pend0, pend1;
	logic       launch;
	logic [1:0] l0, l1;
	assign launch = full_en ? rise : fall; // RULE17
	assign l0 = full_en ? pend0 : n0;
	assign l1 = full_en ? pend1 : n1;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pend0 <= 2'b00;
			pend1 <= 2'b00;
		end else if (fall) begin
			pend0 <= n0;
			pend1 <= n1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_dout <= 1'b0;
			o_dout_oe <= 1'b0;
			o_general_output_pin <= 1'b0;
			o_general_output_oe <= 1'b0;
			o_keeper_en <= 1'b0;
		end else begin
			o_keeper_en <= hold_en; // RULE14
			if (launch) begin // RULE3 RULE9
				o_dout_oe <= l0[1];
				o_dout <= l0[1] ? l0[0] : (hold_en & o_dout);
				o_general_output_oe <= l1[1];
				o_general_output_pin <= l1[1] ? l1[0] :
					(hold_en & o_general_output_pin);
			end
		end
	end

	// frame rate and ratio measurement
	logic [15:0] fclk;
	logic [11:0] rcnt;
	logic        seen, ratio_ok, cfg_ok;
	always_comb begin
		case (rcnt)
			12'h010, 12'h018, 12'h020, 12'h030, 12'h040, 12'h060,
			12'h080, 12'h0c0, 12'h100, 12'h180, 12'h200, 12'h400,
			12'h800: ratio_ok = 1'b1;
			default: ratio_ok = 1'b0;
		endcase
	end
	assign cfg_ok = ratio_ok && fclk >= FR_MIN_CLKS && // RULE21 RULE22
		fclk <= 16'(FR_MAX_CLKS) &&
		32'(rcnt) * CLK_KHZ <= 32'(fclk) * BCLK_MAX_KHZ &&
		32'(rcnt) * CLK_KHZ >= 32'(fclk) * BCLK_MIN_KHZ;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			fclk <= 16'h0000;
			rcnt <= 12'h000;
			seen <= 1'b0;
			o_clock_error <= 1'b0;
			o_cfg_valid <= 1'b0;
			o_cfg_ratio <= 12'h000;
			o_cfg_frame_clks <= 16'h0000;
		end else if (fs_lvl && !fs_q) begin
			fclk <= 16'h0001;
			rcnt <= {11'h000, rise};
			seen <= 1'b1;
			if (seen) begin // RULE20
				o_cfg_ratio <= rcnt;
				o_cfg_frame_clks <= fclk;
				o_cfg_valid <= cfg_ok;
				o_clock_error <= ~cfg_ok; // RULE23
			end
		end else begin
			if (fclk != 16'hffff) begin
				fclk <= fclk + 16'h0001;
			end
			if (rise && rcnt != 12'hfff) begin
				rcnt <= rcnt + 12'h001;
			end
			if (seen && fclk > 16'(FR_MAX_CLKS)) begin
				o_clock_error <= 1'b1;
				o_cfg_valid <= 1'b0;
			end
		end
	end

	// register read port, data one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= 32'h0000_0000;
		end else if (!sel_rd) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_addr == A_CTRL) begin
			o_rdata <= {16'h0000, ctrl};
		end else if (i_addr == A_MHALF) begin
			o_rdata <= {20'h00000, mhalf};
		end else if (i_addr[7:3] == A_SLOT0[7:3]) begin
			o_rdata <= {25'h0000000, slot_cfg[i_addr[2:0]]};
		end else if (i_addr[7:3] == A_SAMP0[7:3]) begin
			o_rdata <= samp[i_addr[2:0]];
		end else if (i_addr == A_STATUS) begin
			o_rdata <= {18'h00000, o_cfg_valid, o_clock_error, o_cfg_ratio};
		end else if (i_addr == A_FCLKS) begin
			o_rdata <= {16'h0000, o_cfg_frame_clks};
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	// checks
	sequence s_half_start_i2s;
		fall && hs && is_i2s && ofs == 5'h00;
	endsequence
	sequence s_half_start_lj;
		fall && hs && fmt == FMT_LJ && ofs == 5'h00;
	endsequence
	chk_i2s_one_delay: assert property (s_half_start_i2s |=> // RULE1 RULE2
		skip == 6'h00 && sbit == 5'h00 && slot == 6'h00)
		else $error("i2s msb not held back one bit clock");
	chk_lj_no_delay: assert property (s_half_start_lj |=> // RULE7 RULE8
		slot[5] || sbit == 5'h01 || wl_last == 5'h00)
		else $error("lj msb not sent in frame sync cycle");
	chk_data_on_fall: assert property (!full_en && // RULE3 RULE9
		$changed(o_dout_oe) && $stable(ctrl) |-> $past(fall))
		else $error("data enable changed off a falling edge");
	chk_frame_sync_pin_on_fall: assert property (master && // RULE3
		$changed(o_frame_sync_pin) |-> $fell(o_bclk))
		else $error("driven frame sync changed off a falling edge");
	chk_tri_idle: assert property (fall && !full_en && !hit[0] && // RULE13
		!(|(hit & m0)) && tri_en && !daisy_en |=> !o_dout_oe)
		else $error("idle slot still driven with tristate on");
	chk_zero_idle: assert property (fall && !full_en && // RULE25
		!(|(hit & m0)) && !tri_en && !daisy_en |=> o_dout_oe && !o_dout)
		else $error("idle slot not driven low");
	chk_mute_err: assert property (o_clock_error && fall && // RULE23
		!full_en && !daisy_en && $stable(o_clock_error) |=>
		!(o_dout && o_dout_oe))
		else $error("data not muted on clock error");
	chk_hold_level: assert property (hold_en && !o_dout_oe && // RULE14
		$past(hold_en) && !$past(o_dout_oe) |-> $stable(o_dout))
		else $error("bus holder lost the level");
	chk_bcast_write: assert property (i_wr && i_broadcast && // RULE19
		i_addr == A_CTRL |=> ctrl == $past(i_wdata[15:0]))
		else $error("broadcast write not taken");
	chk_bad_ratio: assert property (fs_lvl && !fs_q && seen && // RULE21
		!ratio_ok |=> o_clock_error && !o_cfg_valid)
		else $error("unsupported ratio not flagged");
endmodule
`default_nettype wire

// ---- dv/mcap_host_model.sv ----
// host serial port model: bit clock, frame sync and bit capture
`timescale 1ns/1ps
`default_nettype none
module mcap_host_model (
	input  wire logic i_clk,
	input  wire logic i_en,
	input  wire logic i_dout,
	input  wire logic i_dout_oe,
	input  wire logic i_dout2,
	input  wire logic i_dout2_oe,
	output logic      o_bclk,
	output logic      o_fs
);
	int         cnt;
	int         nf;
	int         pos;
	logic [3:0] rec [2][64];
	initial begin
		o_bclk = 1'b1;
		o_fs = 1'b0;
		cnt = 0;
		nf = 0;
		pos = 0;
	end
	// eight-clock bit clock, stands still while disabled
	always @(posedge i_clk) begin
		if (i_en) begin
			cnt <= (cnt == 7) ? 0 : cnt + 1;
			if (cnt == 3) begin
				o_bclk <= 1'b0;
				nf <= (nf == 63) ? 0 : nf + 1;
				if (nf == 63) begin
					o_fs <= ~o_fs;
					pos <= 0;
				end
			end
			// receiver samples on the rising edge
			if (cnt == 7) begin
				o_bclk <= 1'b1;
				if (pos < 64)
					rec[o_fs][pos] <= {i_dout2_oe, i_dout2, i_dout_oe, i_dout};
				pos <= pos + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/mcap_tb_top.sv ----
// self-checking bench for the audio serial transmit port
`timescale 1ns/1ps
`default_nettype none
module mcap_tb_top;
	import mcap_pkg::*;
	logic        clk, srst, wr, rd, bcast, host_en;
	logic        bclk, fs, dout, dout_oe, mbclk, mbclk_oe, mfs, mfs_oe;
	logic        keep, cerr, cvalid, tri_on, hold, full, lane2, daisy;
	logic        dout2, dout2_oe, inv_on, gip;
	logic [1:0]  target, fmt, got, e, got2, e2;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, rv;
	logic [11:0] cratio;
	logic [15:0] cfclks;
	logic [31:0] samp [8];
	int          slot [8];
	int          num_errors, check_count, seed, w, d, ofs, q, tg;

	mcap_top #(.FR_MAX_CLKS(2000)) u_mcap_top (
		.i_clk(clk), .i_srst(srst), .i_addr_strap(2'b10),
		.i_target(target), .i_broadcast(bcast), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_bclk(bclk ^ inv_on), .i_frame_sync_pin(fs),
		.i_general_input_pin(gip),
		.o_bclk(mbclk), .o_bclk_oe(mbclk_oe), .o_frame_sync_pin(mfs),
		.o_frame_sync_oe(mfs_oe), .o_dout(dout), .o_dout_oe(dout_oe),
		.o_general_output_pin(dout2), .o_general_output_oe(dout2_oe),
		.o_keeper_en(keep), .o_clock_error(cerr), .o_cfg_valid(cvalid),
		.o_cfg_ratio(cratio), .o_cfg_frame_clks(cfclks));

	mcap_host_model u_mcap_host_model (
		.i_clk(clk), .i_en(host_en), .i_dout(dout),
		.i_dout_oe(dout_oe), .i_dout2(dout2), .i_dout2_oe(dout2_oe),
		.o_bclk(bclk), .o_fs(fs));

	// 100 mhz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] sv, input logic [31:0] xv);
		check_count++;
		if (sv !== xv) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, sv, xv);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] dv);
		@(posedge clk);
		addr <= a;
		wdata <= dv;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [31:0] dv);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		dv = rdata;
	endtask

	task automatic final_report;
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		#800000;
		num_errors++;
		final_report;
	end

	// main sequence
	initial begin
		seed = 32'hefc8258f;
		srst = 1'b1;
		{wr, rd, bcast} = 3'b000;
		{inv_on, gip} = 2'b00;
		host_en = 1'b1;
		target = 2'b10;
		addr = 8'h00;
		wdata = 32'h0;
		slot = '{0, 1, 33, -1, 2, 32, -1, -1};
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rreg(A_CTRL, rv);
		chk(rv, 32'(CTRL_RST));
		rreg(8'hff, rv);
		chk(rv, 32'h0);
		// foreign target ignored, broadcast taken
		target <= 2'b01;
		wreg(A_CTRL, 32'h2);
		target <= 2'b10;
		rreg(A_CTRL, rv);
		chk(rv, 32'(CTRL_RST));
		target <= 2'b01;
		bcast <= 1'b1;
		wreg(A_CTRL, 32'h2);
		bcast <= 1'b0;
		target <= 2'b10;
		rreg(A_CTRL, rv);
		chk(rv, 32'h2);
		// random samples and slot map
		for (int c = 0; c < 8; c++) begin
			samp[c] = $random(seed);
			wreg(A_SAMP0 + 8'(c), samp[c]);
			wreg(A_SLOT0 + 8'(c), slot[c] < 0 ? 32'h0 : 32'(slot[c]) | 32'h40);
		end
		// both framings, every word length, offsets 0 to 3, each lane, chain and launch mode
		for (int r = 0; r < 16; r++) begin
			fmt = r[0] ? FMT_LJ : FMT_I2S;
			ofs = r / 4;
			w = (r % 4 == 0) ? 16 : (r % 4 == 1) ? 20 : (r % 4 == 2) ? 24 : 32;
			d = (fmt == FMT_I2S) ? 1 : 0;
			d += r[3]; // full-cycle capture sees each bit one rise later
			{tri_on, hold, full} = {r[1], r[2] ^ r[0], r[3]};
			{lane2, daisy} = {r[1] ^ r[2], r[0] & ~r[1]};
			inv_on <= full;
			gip <= 1'($random(seed));
			wreg(A_CTRL, 32'(fmt) | 32'(r % 4) << F_WLEN
				| 32'(tri_on) << F_TRI | 32'(hold) << F_HOLD
				| 32'(lane2) << F_LANE2 | 32'(daisy) << F_DAISY
				| 32'(full) << F_FULL | 32'(full) << F_INV
				| 32'(ofs) << F_OFS);
			repeat (3300) @(posedge clk);
			chk(32'(keep), 32'(hold));
			for (int h = 0; h < 2; h++) begin
				tg = (fmt == FMT_I2S) ? h : 1 - h;
				for (int p = d + ofs; p < 64; p++) begin
					{got2, got} = u_mcap_host_model.rec[tg][p];
					q = p - d - ofs;
					e = daisy ? {1'b1, gip} : tri_on ? 2'b00 : 2'b10;
					e2 = (lane2 && !tri_on) ? 2'b10 : 2'b00;
					for (int c = 0; c < 8; c++) begin
						if (lane2 && c > 3 && slot[c] == h * 32 + q / w)
							e2 = {1'b1, samp[c][31 - q % w]};
						else if (slot[c] == h * 32 + q / w)
							e = {1'b1, samp[c][31 - q % w]};
					end
					if (e[1])
						chk(32'(got), 32'(e));
					else
						chk(32'(got[1]), 32'h0);
					if (e2[1])
						chk(32'(got2), 32'(e2));
					else
						chk(32'(got2[1]), 32'h0);
				end
			end
		end
		// clock measurement of 128 bclks a frame
		chk(32'(cratio), 32'd128);
		chk({cerr, cvalid}, 32'h1);
		rreg(A_STATUS, rv);
		chk(rv, 32'h2080);
		rreg(A_FCLKS, rv);
		chk(rv, 32'd1024);
		chk(32'(cfclks), 32'd1024);
		// master: bit clock edge every four cycles, frame sync every 32 bclks
		inv_on <= 1'b0;
		wreg(A_CTRL, 32'h1 << F_MASTER | 32'(FMT_I2S));
		repeat (4) @(posedge clk);
		#1;
		q = 0;
		tg = 0;
		for (int i = 0; i < 520; i++) begin
			rv[1:0] = {mfs, mbclk};
			@(posedge clk);
			#1;
			q += (rv[0] !== mbclk);
			tg += (rv[1] !== mfs);
		end
		chk({mbclk_oe, mfs_oe}, 32'h3);
		chk(32'(q), 32'd130);
		chk(32'(tg), 32'd2);
		// lost clocks flag an error, good frames clear it
		wreg(A_CTRL, 32'(FMT_I2S));
		host_en <= 1'b0;
		repeat (2200) @(posedge clk);
		chk(32'(cerr), 32'h1);
		host_en <= 1'b1;
		repeat (3200) @(posedge clk);
		chk(32'(cerr), 32'h0);
		final_report;
	end
endmodule
`default_nettype wire
